/* File: pkg/srtc_pkg.sv */
`default_nettype none
package srtc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices, byte address is four times the index
  localparam logic [15:0] IDX_WR_COUNTER = 16'h4020;
  localparam logic [15:0] IDX_SECS_HIGH = 16'h4021;
  localparam logic [15:0] IDX_SECS_LOW = 16'h4022;
  localparam logic [15:0] IDX_ALARM_HIGH = 16'h4023;
  localparam logic [15:0] IDX_ALARM_LOW = 16'h4024;
  localparam logic [15:0] IDX_CONTROL = 16'h4025;
  localparam logic [15:0] IDX_TRIM = 16'h4026;
  localparam logic [15:0] IDX_EVENTS = 16'h4027;
  localparam logic [15:0] IDX_KEY = 16'h4028;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_VALID_BIT = 15;
  localparam int CTL_BUSY_BIT = 14;
  localparam int CTL_ALM_EN_BIT = 10;
  localparam int CTL_PER_LSB = 4;
  localparam int CTL_PER_W = 3;
  localparam int TRIM_W = 10;
  localparam int TRIM_FRAC_BITS = 6;
  localparam int EVT_ALARM_BIT = 0;
  localparam int EVT_TICK_BIT = 1;
  localparam int KEY_OPEN_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and key
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [31:0] RST_REG32 = 32'h0000_0000;
  localparam logic [15:0] RST_LFSR = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  // Unlock value is arbitrary
  localparam logic [15:0] KEY_UNLOCK = 16'h9716;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_BUSY_NS = 100;
  localparam int SYNC_BUSY_CYCLES = (SYNC_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTAL_NOMINAL_HZ = 32768;
  localparam int ACC_W = 23;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } srtc_req_s;

endpackage
`default_nettype wire

/* File: rtl/srtc_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module srtc_tick
  import srtc_pkg::*;
#(
  parameter int XTAL_HZ = XTAL_NOMINAL_HZ
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic xtal_in,
  input wire logic [TRIM_W-1:0] trim,
  output logic sec_pulse
);

  // ----------------------------------------------------------------
  // Crystal pin synchroniser
  // ----------------------------------------------------------------
  logic s1_r, s2_r, s3_r, level_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] threshold;
  logic xtal_rise;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= xtal_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign xtal_rise = s2_r & s3_r & ~level_r;

  // ----------------------------------------------------------------
  // Fractional second accumulator
  // ----------------------------------------------------------------
  // Units of 1/64 crystal cycle; the signed trim moves the second length
  assign threshold = ACC_W'(XTAL_HZ << TRIM_FRAC_BITS)
                   + {{(ACC_W-TRIM_W){trim[TRIM_W-1]}}, trim};

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= '0;
      sec_pulse <= 1'b0;
    end else begin
      sec_pulse <= 1'b0;
      if (xtal_rise) begin
        // Remainder carried over, so fractional trim is not lost
        if (acc_r + ACC_W'(1 << TRIM_FRAC_BITS) >= threshold) begin
          acc_r <= acc_r + ACC_W'(1 << TRIM_FRAC_BITS) - threshold;
          sec_pulse <= 1'b1;
        end else begin
          acc_r <= acc_r + ACC_W'(1 << TRIM_FRAC_BITS);
        end
      end
    end
  end

endmodule // srtc_tick
`default_nettype wire

/* File: rtl/srtc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module srtc_top
  import srtc_pkg::*;
#(
  // Crystal rate in hertz; only a bench shortens it, to make seconds short
  parameter int XTAL_HZ = XTAL_NOMINAL_HZ
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic xtal_in,
  input wire srtc_req_s avs_req,
  output logic avs_waitrequest,
  output logic [DATA_W-1:0] avs_readdata,
  output logic alarm_event,
  output logic tick_event
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old_v,
    input logic [DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [REG_W-1:0] v;
    v = old_v;
    if (be[0]) begin
      v[7:0] = wd[7:0];
    end
    if (be[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  // Low n bits of the count, all zero exactly on a 2^n second boundary
  function automatic logic [31:0] period_mask(input logic [CTL_PER_W-1:0] code);
    logic [31:0] m;
    m = (32'h0000_0001 << code) - 32'h0000_0001;
    return m;
  endfunction

  // Either half counts as a time write, for the valid flag and the counter
  function automatic logic hits_secs(input logic [15:0] i);
    return (i == IDX_SECS_HIGH) || (i == IDX_SECS_LOW);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] secs_r, secs_nxt;
  logic [31:0] alarm_r;
  logic [REG_W-1:0] wr_cnt_r;
  logic [REG_W-1:0] lfsr_r;
  logic valid_r;
  logic alm_en_r;
  logic [CTL_PER_W-1:0] period_r;
  logic [TRIM_W-1:0] trim_r;
  logic key_open_r;
  logic [1:0] events_r;
  logic [2:0] busy_cnt_r;
  logic match_q_r;
  logic sec_pulse;
  logic [15:0] idx;
  logic access;
  logic wr_go;
  logic rd_go;
  logic [REG_W-1:0] rd_word;
  logic per_hit;
  logic alm_hit;

  // ----------------------------------------------------------------
  // Second generator
  // ----------------------------------------------------------------
  // Trim reaches the divider straight from its register, so a new value
  // applies from the next crystal edge without restarting the second
  srtc_tick #(
    .XTAL_HZ(XTAL_HZ)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .xtal_in(xtal_in),
    .trim(trim_r),
    .sec_pulse(sec_pulse)
  );

  // ----------------------------------------------------------------
  // Avalon slave handshake
  // ----------------------------------------------------------------
  // One wait state: the request is accepted at the edge after it rises,
  // where a read latches its data; a write takes effect at the edge where waitrequest is seen low
  assign idx = avs_req.address[ADDR_W-1:2];
  assign access = (avs_req.read | avs_req.write) & avs_waitrequest;
  assign wr_go = avs_req.write & ~avs_waitrequest;
  assign rd_go = avs_req.read & avs_waitrequest;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if (access) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_word = RST_REG16;
    unique case (idx)
      IDX_WR_COUNTER: rd_word = wr_cnt_r;
      IDX_SECS_HIGH: rd_word = secs_r[31:16];
      IDX_SECS_LOW: rd_word = secs_r[15:0];
      IDX_ALARM_HIGH: rd_word = alarm_r[31:16];
      IDX_ALARM_LOW: rd_word = alarm_r[15:0];
      IDX_CONTROL: begin
        rd_word[CTL_VALID_BIT] = valid_r;
        rd_word[CTL_BUSY_BIT] = (busy_cnt_r != 3'd0);
        rd_word[CTL_ALM_EN_BIT] = alm_en_r;
        rd_word[CTL_PER_LSB +: CTL_PER_W] = period_r;
      end
      IDX_TRIM: rd_word[TRIM_W-1:0] = trim_r;
      IDX_EVENTS: rd_word[1:0] = events_r;
      IDX_KEY: rd_word[KEY_OPEN_BIT] = key_open_r;
      default: rd_word = RST_REG16;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= RST_REG32;
    end else if (rd_go) begin
      avs_readdata <= {16'h0000, rd_word};
    end
  end

  // ----------------------------------------------------------------
  // Seconds counter
  // ----------------------------------------------------------------
  // A software write to one half overrides that half only; the other half
  // keeps any increment from the same cycle
  always_comb begin
    secs_nxt = sec_pulse ? secs_r + 32'h0000_0001 : secs_r;
    if (wr_go && idx == IDX_SECS_HIGH) begin
      secs_nxt[31:16] = merge16(secs_r[31:16], avs_req.writedata, avs_req.byteenable);
    end
    if (wr_go && idx == IDX_SECS_LOW) begin
      secs_nxt[15:0] = merge16(secs_r[15:0], avs_req.writedata, avs_req.byteenable);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      secs_r <= RST_REG32;
    end else begin
      secs_r <= secs_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_r <= 1'b0;
    end else if (wr_go && hits_secs(idx)) begin
      valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Tamper write counter
  // ----------------------------------------------------------------
  // Free running LFSR so the value loaded cannot be predicted from the
  // number of writes alone
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lfsr_r <= RST_LFSR;
    end else begin
      lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_cnt_r <= RST_REG16;
    end else if (wr_go && hits_secs(idx)) begin
      wr_cnt_r <= lfsr_r;
    end
  end

  // ----------------------------------------------------------------
  // Alarm registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_r <= RST_REG32;
    end else if (wr_go && idx == IDX_ALARM_HIGH) begin
      alarm_r[31:16] <= merge16(alarm_r[31:16], avs_req.writedata, avs_req.byteenable);
    end else if (wr_go && idx == IDX_ALARM_LOW) begin
      alarm_r[15:0] <= merge16(alarm_r[15:0], avs_req.writedata, avs_req.byteenable);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      alm_en_r <= 1'b0;
      period_r <= '0;
    end else if (wr_go && idx == IDX_CONTROL) begin
      if (avs_req.byteenable[1]) begin
        alm_en_r <= avs_req.writedata[CTL_ALM_EN_BIT];
      end
      if (avs_req.byteenable[0]) begin
        period_r <= avs_req.writedata[CTL_PER_LSB +: CTL_PER_W];
      end
    end
  end

  // Busy covers the settling time after any clock register write; the
  // device still accepts writes during it, keeping off is software's job
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_r <= 3'd0;
    end else if (wr_go && idx >= IDX_SECS_HIGH && idx <= IDX_TRIM) begin
      busy_cnt_r <= 3'(SYNC_BUSY_CYCLES);
    end else if (busy_cnt_r != 3'd0) begin
      busy_cnt_r <= busy_cnt_r - 3'd1;
    end
  end

  // ----------------------------------------------------------------
  // Security key and trim
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      key_open_r <= 1'b0;
    end else if (wr_go && idx == IDX_KEY) begin
      key_open_r <= (avs_req.writedata[15:0] == KEY_UNLOCK);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_r <= '0;
    end else if (wr_go && idx == IDX_TRIM && key_open_r) begin
      trim_r <= TRIM_W'(merge16({6'h00, trim_r}, avs_req.writedata, avs_req.byteenable));
    end
  end

  // ----------------------------------------------------------------
  // Alarm and periodic events
  // ----------------------------------------------------------------
  // Alarm fires once on entering the match, not every cycle it lasts
  assign alm_hit = alm_en_r && (secs_r == alarm_r) && !match_q_r;
  assign per_hit = sec_pulse && (period_r != '0)
                && ((secs_nxt & period_mask(period_r)) == 32'h0000_0000);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      match_q_r <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      match_q_r <= alm_en_r && (secs_r == alarm_r);
      alarm_event <= alm_hit;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_event <= 1'b0;
    end else begin
      tick_event <= per_hit;
    end
  end

  // Sticky copies for polling, write one to clear, a new event wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      events_r <= 2'b00;
    end else begin
      if (wr_go && idx == IDX_EVENTS && avs_req.byteenable[0]) begin
        events_r <= (events_r & ~avs_req.writedata[1:0]) | {per_hit, alm_hit};
      end else begin
        events_r <= events_r | {per_hit, alm_hit};
      end
    end
  end

endmodule // srtc_top
`default_nettype wire

/* File: verification/srtc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module srtc_checker
  import srtc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire srtc_req_s avs_req,
  input wire logic avs_waitrequest,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic alarm_event,
  input wire logic tick_event
);
  // ------
  // Shadow state
  // ------
  logic done;
  logic [15:0] idx;
  logic rd_ctl;
  logic valid_r;
  logic en_r;
  logic [3:0] gap_r;
  assign done = !avs_waitrequest && (avs_req.read || avs_req.write);
  assign idx = avs_req.address[17:2];
  assign rd_ctl = done && avs_req.read && idx == IDX_CONTROL;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_r <= 1'b0;
    end else if (done && avs_req.write && (idx == IDX_SECS_HIGH || idx == IDX_SECS_LOW)) begin
      valid_r <= 1'b1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 1'b0;
    end else if (done && avs_req.write && idx == IDX_CONTROL) begin
      en_r <= avs_req.writedata[CTL_ALM_EN_BIT];
    end
  end
  // Saturates so that a stale write never looks recent
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= 4'hF;
    end else if (done && avs_req.write && idx >= IDX_SECS_HIGH && idx <= IDX_TRIM) begin
      gap_r <= 4'h0;
    end else if (gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_answer_one_wait: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("No answer after one wait state");
  a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Wait low longer than one cycle");
  a_upper_zero: assert property (done && avs_req.read |-> avs_readdata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");
  a_valid_flag: assert property (rd_ctl |-> avs_readdata[CTL_VALID_BIT] == valid_r)
    else $error("Valid bit wrong");
  a_busy_window: assert property (rd_ctl |-> (gap_r <= 4'h2) ? avs_readdata[CTL_BUSY_BIT]
    : (gap_r != 4'hF || !avs_readdata[CTL_BUSY_BIT])) else $error("Busy bit wrong");
  a_ctl_unused: assert property (rd_ctl |-> (avs_readdata[15:0] & 16'h3B8F) == 16'h0000)
    else $error("Control unused bits set");
  a_trim_width: assert property (done && avs_req.read && idx == IDX_TRIM
    |-> avs_readdata[15:10] == 6'h00) else $error("Trim above bit 9 set");
  a_alarm_enabled: assert property (alarm_event |-> en_r || $past(en_r))
    else $error("Alarm while disabled");
  a_alarm_pulse: assert property (alarm_event |=> !alarm_event)
    else $error("Alarm pulse too long");
  a_tick_pulse: assert property (tick_event |=> !tick_event)
    else $error("Tick pulse too long");
  c_alarm: cover property (alarm_event);
  c_ctl_read: cover property (rd_ctl && avs_readdata[CTL_BUSY_BIT]);
  c_trim_read: cover property (done && avs_req.read && idx == IDX_TRIM);
  c_tick: cover property (tick_event);
endmodule // srtc_checker
`default_nettype wire

/* File: verification/srtc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module srtc_top_bench
  import srtc_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  // Stands still outside run_xtal, so the count moves only where a scenario wants it
  logic xtal_in = 1'b0;
  logic xtal_run = 1'b0;
  logic [1:0] xtal_div = 2'b00;
  int ticks = 0;
  srtc_req_s avs_req = '0;
  logic avs_waitrequest;
  logic [DATA_W-1:0] avs_readdata;
  logic alarm_event;
  logic tick_event;
  int num_errors = 0;
  int checks_done = 0;
  int alarms = 0;
  logic [15:0] rd;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (alarm_event === 1'b1) alarms <= alarms + 1;
  always @(posedge mclk) if (tick_event === 1'b1) ticks <= ticks + 1;
  // Crystal at one eighth of mclk, high and low four cycles each
  always @(posedge mclk) begin
    if (xtal_run) begin
      xtal_div <= xtal_div + 2'b01;
      if (xtal_div == 2'b11) begin
        xtal_in <= ~xtal_in;
      end
    end
  end
  // Sixteen rising crystal edges make a second, short enough for the run
  srtc_top #(.XTAL_HZ(16)) uut (.mclk(mclk), .sys_rst(sys_rst), .xtal_in(xtal_in),
    .avs_req(avs_req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .alarm_event(alarm_event), .tick_event(tick_event));
  // ------
  // Shared tasks
  // ------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [15:0] idx, logic [15:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {16'h0000, wd},
      byteenable: 4'hF};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[15:0];
    avs_req <= '0;
    if (n >= 50) check("bus answer", 16'h0000, 16'h0001);
  endtask
  task automatic wr_clk(logic [15:0] idx, logic [15:0] wd);
    int n;
    n = 0;
    do begin
      bus(1'b0, IDX_CONTROL, 16'h0000);
      n++;
    end while (rd[CTL_BUSY_BIT] !== 1'b0 && n < 20);
    bus(1'b1, idx, wd);
  endtask
  task automatic settle();
    repeat (12) @(posedge mclk);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_seconds();
    logic [15:0] c0;
    bus(1'b0, IDX_CONTROL, 16'h0000);
    check("control after reset", rd, 16'h0000);
    bus(1'b0, IDX_WR_COUNTER, 16'h0000);
    c0 = rd;
    wr_clk(IDX_SECS_HIGH, 16'h1234);
    bus(1'b0, IDX_WR_COUNTER, 16'h0000);
    check("counter moved", 16'(rd !== c0), 16'h0001);
    c0 = rd;
    wr_clk(IDX_SECS_LOW, 16'hABCD);
    bus(1'b0, IDX_CONTROL, 16'h0000);
    check("valid bit", 16'(rd[CTL_VALID_BIT]), 16'h0001);
    check("busy bit", 16'(rd[CTL_BUSY_BIT]), 16'h0001);
    bus(1'b0, IDX_WR_COUNTER, 16'h0000);
    check("counter moved again", 16'(rd !== c0), 16'h0001);
    bus(1'b0, IDX_SECS_HIGH, 16'h0000);
    check("seconds high", rd, 16'h1234);
    bus(1'b0, IDX_SECS_LOW, 16'h0000);
    check("seconds low", rd, 16'hABCD);
    bus(1'b1, 16'h4030, 16'hFFFF);
    bus(1'b0, 16'h4030, 16'h0000);
    check("unmapped", rd, 16'h0000);
  endtask
  task automatic t_alarm();
    int a0;
    wr_clk(IDX_ALARM_HIGH, 16'h1234);
    wr_clk(IDX_ALARM_LOW, 16'hABCE);
    bus(1'b0, IDX_ALARM_HIGH, 16'h0000);
    check("alarm high", rd, 16'h1234);
    bus(1'b0, IDX_ALARM_LOW, 16'h0000);
    check("alarm low", rd, 16'hABCE);
    a0 = alarms;
    wr_clk(IDX_CONTROL, 16'h0400);
    settle();
    check("alarm no match", 16'(alarms - a0), 16'h0000);
    wr_clk(IDX_CONTROL, 16'h0000);
    wr_clk(IDX_SECS_LOW, 16'hABCE);
    settle();
    check("alarm disabled", 16'(alarms - a0), 16'h0000);
    wr_clk(IDX_CONTROL, 16'h0400);
    settle();
    check("alarm raised", 16'(alarms - a0), 16'h0001);
  endtask
  task automatic t_period();
    for (int code = 0; code < 8; code++) begin
      wr_clk(IDX_CONTROL, 16'(code << CTL_PER_LSB));
      bus(1'b0, IDX_CONTROL, 16'h0000);
      check("tick period", rd & 16'h0470, 16'(code << CTL_PER_LSB));
    end
  endtask
  task automatic t_trim();
    logic [15:0] vals [3] = '{16'h0200, 16'h03FF, 16'h01FF};
    wr_clk(IDX_TRIM, 16'h0155);
    bus(1'b0, IDX_TRIM, 16'h0000);
    check("trim locked", rd, 16'h0000);
    bus(1'b1, IDX_KEY, KEY_UNLOCK);
    foreach (vals[i]) begin
      wr_clk(IDX_TRIM, vals[i]);
      bus(1'b0, IDX_TRIM, 16'h0000);
      check("trim value", rd, vals[i]);
    end
    bus(1'b1, IDX_KEY, 16'h0000);
    wr_clk(IDX_TRIM, 16'h0001);
    bus(1'b0, IDX_TRIM, 16'h0000);
    check("trim relocked", rd, 16'h01FF);
  endtask
  // 600 cycles give 75 rising crystal edges, well clear of a second boundary
  task automatic run_xtal();
    xtal_run <= 1'b1;
    repeat (600) @(posedge mclk);
    xtal_run <= 1'b0;
    settle();
  endtask
  task automatic t_run();
    int t0;
    bus(1'b1, IDX_KEY, KEY_UNLOCK);
    wr_clk(IDX_TRIM, 16'h0000);
    wr_clk(IDX_CONTROL, 16'h0010);
    wr_clk(IDX_SECS_HIGH, 16'h0000);
    wr_clk(IDX_SECS_LOW, 16'h0000);
    t0 = ticks;
    run_xtal();
    bus(1'b0, IDX_SECS_LOW, 16'h0000);
    check("seconds counted", rd, 16'h0004);
    bus(1'b0, IDX_SECS_HIGH, 16'h0000);
    check("seconds high held", rd, 16'h0000);
    check("ticks every 2 s", 16'(ticks - t0), 16'h0002);
    // Minus 8 Hz halves the second; 704/64 crystal cycles are carried in
    wr_clk(IDX_TRIM, 16'h0200);
    wr_clk(IDX_SECS_LOW, 16'h0000);
    t0 = ticks;
    run_xtal();
    bus(1'b0, IDX_SECS_LOW, 16'h0000);
    check("seconds trimmed", rd, 16'h000A);
    check("ticks trimmed", 16'(ticks - t0), 16'h0005);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    bus(1'b0, IDX_CONTROL, 16'h0000);
    check("control after second reset", rd, 16'h0000);
    bus(1'b0, IDX_SECS_LOW, 16'h0000);
    check("seconds after second reset", rd, 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    t_seconds();
    t_alarm();
    t_period();
    t_trim();
    t_run();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    conclude();
  end
endmodule // srtc_top_bench
bind srtc_top srtc_checker chk (.mclk(mclk), .sys_rst(sys_rst), .avs_req(avs_req),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .alarm_event(alarm_event), .tick_event(tick_event));
`default_nettype wire
